// ==== hw/rsc_config.sv ====
// Purpose: APB register bank for rate converter phase steps and threshold
// Assumes: APB3 slave, one wait-free access phase, byte data in low bits
// Notes:   step outputs drive both channels of each converter
// What this block does
// - each step is low byte, middle byte and two top bits, 18 bits.
// - the step is the in/out rate ratio with 16 fraction bits.
// - each converter has one step shared by left and right channels.
// - converter 1 resets to low 7C, middle 86, top bits 01.
// - converter 2 resets to the same values as converter 1.
// - converters 3 and 4 reset to low AA, middle 4F; conv 3 top 01.
// - converter 3 gates fifo read enable on a 4-bit level, reset 08.
// - converter 3's read level applies to both channel fifos.
//
// The implementer's own choice: register access over APB.
`default_nettype none
module rsc_config
  import rsc_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [15:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic      [31:0]        prdata,
  output logic                    pslverr,
  input  wire logic [LEVEL_W-1:0] conv3_fill_left,
  input  wire logic [LEVEL_W-1:0] conv3_fill_right,
  output logic      [STEP_W-1:0]  conv1_step,
  output logic      [STEP_W-1:0]  conv2_step,
  output logic      [STEP_W-1:0]  conv3_step,
  output logic      [STEP_W-1:0]  conv4_step,
  output logic                    conv1_unity,
  output logic                    conv3_rd_en_left,
  output logic                    conv3_rd_en_right
);
  rsc_state_e  state_r, state_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [3:0]  conv3_read_level_r, conv3_read_level_nxt;
  logic [11:0] idx;
  logic        setup, acc_cyc, wr_cyc, mapped, aligned;
  logic [7:0]  wd, rd_byte;
  logic [STEP_W-1:0] s1, s2, s3, s4;
  logic        u1;

  assign idx     = paddr[13:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
  assign wd      = pwdata[7:0];
  assign setup   = psel && !penable && (state_r == RSC_IDLE);
  // write lands at the access edge, where the master sees pready
  assign acc_cyc = psel && penable && (state_r == RSC_ACCESS);
  assign wr_cyc  = acc_cyc && pwrite && mapped;

  rsc_step_reg #(
    .RST_LOW (RST_C12_LOW),
    .RST_MID (RST_C12_MID),
    .RST_HI  (RST_TOP),
    .HAS_TOP (1'b1)
  ) u_conv1 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_low  (wr_cyc && idx == IDX_C1_LOW),
    .wr_mid  (wr_cyc && idx == IDX_C1_MID),
    .wr_top  (wr_cyc && idx == IDX_C1_TOP),
    .wdata   (wd),
    .step    (s1),
    .unity   (u1)
  );
  rsc_step_reg #(
    .RST_LOW (RST_C12_LOW),
    .RST_MID (RST_C12_MID),
    .RST_HI  (RST_TOP),
    .HAS_TOP (1'b1)
  ) u_conv2 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_low  (wr_cyc && idx == IDX_C2_LOW),
    .wr_mid  (wr_cyc && idx == IDX_C2_MID),
    .wr_top  (wr_cyc && idx == IDX_C2_TOP),
    .wdata   (wd),
    .step    (s2),
    .unity   ()
  );
  rsc_step_reg #(
    .RST_LOW (RST_C34_LOW),
    .RST_MID (RST_C34_MID),
    .RST_HI  (RST_TOP),
    .HAS_TOP (1'b1)
  ) u_conv3 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_low  (wr_cyc && idx == IDX_C3_LOW),
    .wr_mid  (wr_cyc && idx == IDX_C3_MID),
    .wr_top  (wr_cyc && idx == IDX_C3_TOP),
    .wdata   (wd),
    .step    (s3),
    .unity   ()
  );
  // top bits of converter 4 lie outside this bank; held at reset value
  rsc_step_reg #(
    .RST_LOW (RST_C34_LOW),
    .RST_MID (RST_C34_MID),
    .RST_HI  (RST_TOP),
    .HAS_TOP (1'b0)
  ) u_conv4 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_low  (wr_cyc && idx == IDX_C4_LOW),
    .wr_mid  (wr_cyc && idx == IDX_C4_MID),
    .wr_top  (1'b0),
    .wdata   (wd),
    .step    (s4),
    .unity   ()
  );

  // one shared threshold feeds both channel gates
  rsc_read_gate u_gate_left (
    .pclk    (pclk),
    .presetn (presetn),
    .fill    (conv3_fill_left),
    .level   (conv3_read_level_r),
    .rd_en   (conv3_rd_en_left)
  );
  rsc_read_gate u_gate_right (
    .pclk    (pclk),
    .presetn (presetn),
    .fill    (conv3_fill_right),
    .level   (conv3_read_level_r),
    .rd_en   (conv3_rd_en_right)
  );

  // address decode and read mux
  always_comb begin
    mapped  = aligned;
    rd_byte = 8'h00;
    if (!aligned) begin
      mapped = 1'b0;
    end else begin
      case (idx)
        IDX_C1_LOW: rd_byte = s1[7:0];
        IDX_C1_MID: rd_byte = s1[15:8];
        IDX_C1_TOP: rd_byte = {6'h00, s1[17:16]};
        IDX_TEST_A: rd_byte = RST_TEST;
        IDX_C2_LOW: rd_byte = s2[7:0];
        IDX_C2_MID: rd_byte = s2[15:8];
        IDX_C2_TOP: rd_byte = {6'h00, s2[17:16]};
        IDX_TEST_B: rd_byte = RST_TEST;
        IDX_C3_LOW: rd_byte = s3[7:0];
        IDX_C3_MID: rd_byte = s3[15:8];
        IDX_C3_TOP: rd_byte = {6'h00, s3[17:16]};
        IDX_C3_LVL: rd_byte = {4'h0, conv3_read_level_r};
        IDX_C4_LOW: rd_byte = s4[7:0];
        IDX_C4_MID: rd_byte = s4[15:8];
        default:    mapped  = 1'b0;
      endcase
    end
  end

  always_comb begin
    conv3_read_level_nxt = conv3_read_level_r;
    if (wr_cyc && idx == IDX_C3_LVL) begin
      conv3_read_level_nxt = wd[3:0];
    end
  end

  // bus state: answer one cycle after setup, pready only in access
  always_comb begin
    state_nxt   = state_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = 32'h0000_0000;
    case (state_r)
      RSC_IDLE: begin
        if (setup) begin
          state_nxt   = RSC_ACCESS;
          pready_nxt  = 1'b1;
          pslverr_nxt = !mapped;
          prdata_nxt  = (pwrite || !mapped) ? 32'h0000_0000
                                            : {24'h000000, rd_byte};
        end
      end
      RSC_ACCESS: begin
        state_nxt = RSC_IDLE;
      end
      default: state_nxt = RSC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r            <= RSC_IDLE;
      pready_r           <= 1'b0;
      pslverr_r          <= 1'b0;
      prdata_r           <= 32'h0000_0000;
      conv3_read_level_r <= RST_LEVEL;
      conv1_step         <= {RST_TOP, RST_C12_MID, RST_C12_LOW};
      conv2_step         <= {RST_TOP, RST_C12_MID, RST_C12_LOW};
      conv3_step         <= {RST_TOP, RST_C34_MID, RST_C34_LOW};
      conv4_step         <= {RST_TOP, RST_C34_MID, RST_C34_LOW};
      conv1_unity        <= 1'b0;
    end else begin
      state_r            <= state_nxt;
      pready_r           <= pready_nxt;
      pslverr_r          <= pslverr_nxt;
      prdata_r           <= prdata_nxt;
      conv3_read_level_r <= conv3_read_level_nxt;
      conv1_step         <= s1;
      conv2_step         <= s2;
      conv3_step         <= s3;
      conv4_step         <= s4;
      conv1_unity        <= u1;
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  // checks
  property p_wr_low1;
    @(posedge pclk) disable iff (!presetn)
    (wr_cyc && idx == IDX_C1_LOW) |-> ##2 conv1_step[7:0] == $past(wd, 2);
  endproperty
  a_wr_low1: assert property (p_wr_low1)
    else $error("conv1 low byte not stored");

  property p_top_bits;
    @(posedge pclk) disable iff (!presetn)
    (wr_cyc && idx == IDX_C2_TOP) |-> ##2 conv2_step[17:16] ==
      $past(wd[1:0], 2);
  endproperty
  a_top_bits: assert property (p_top_bits)
    else $error("conv2 top bits not stored");

  property p_unity;
    @(posedge pclk) disable iff (!presetn)
    ##1 (conv1_unity == $past(s1 == STEP_UNITY));
  endproperty
  a_unity: assert property (p_unity)
    else $error("unity flag wrong");

  property p_rsv_read;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && idx == IDX_C3_LVL && aligned) |=>
      pready && prdata[31:4] == 28'h0000000;
  endproperty
  a_rsv_read: assert property (p_rsv_read)
    else $error("reserved bits not zero");

  property p_lvl_wr;
    @(posedge pclk) disable iff (!presetn)
    (wr_cyc && idx == IDX_C3_LVL) |=> conv3_read_level_r == $past(wd[3:0]);
  endproperty
  a_lvl_wr: assert property (p_lvl_wr)
    else $error("read level not stored");

  property p_gate;
    @(posedge pclk) disable iff (!presetn)
    ##1 conv3_rd_en_left == $past(conv3_fill_left >= conv3_read_level_r);
  endproperty
  a_gate: assert property (p_gate)
    else $error("left read enable wrong");

  property p_both;
    @(posedge pclk) disable iff (!presetn)
    (conv3_fill_left == conv3_fill_right) |=>
      conv3_rd_en_left == conv3_rd_en_right;
  endproperty
  a_both: assert property (p_both)
    else $error("channels disagree");

  sequence s_setup;
    setup;
  endsequence
  property p_answer;
    @(posedge pclk) disable iff (!presetn)
    s_setup |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("answer timing wrong");

  property p_mid2;
    @(posedge pclk) disable iff (!presetn)
    (wr_cyc && idx == IDX_C2_MID) |-> ##2 conv2_step[15:8] == $past(wd, 2);
  endproperty
  a_mid2: assert property (p_mid2)
    else $error("conv2 middle byte not stored");

  property p_c3_top;
    @(posedge pclk) disable iff (!presetn)
    (wr_cyc && idx == IDX_C3_TOP) |-> ##2 conv3_step[17:16] ==
      $past(wd[1:0], 2);
  endproperty
  a_c3_top: assert property (p_c3_top)
    else $error("conv3 top bits not stored");

  property p_c4_low;
    @(posedge pclk) disable iff (!presetn)
    (wr_cyc && idx == IDX_C4_LOW) |-> ##2 conv4_step[7:0] == $past(wd, 2);
  endproperty
  a_c4_low: assert property (p_c4_low)
    else $error("conv4 low byte not stored");

  property p_c4_mid;
    @(posedge pclk) disable iff (!presetn)
    (wr_cyc && idx == IDX_C4_MID) |-> ##2 conv4_step[15:8] == $past(wd, 2);
  endproperty
  a_c4_mid: assert property (p_c4_mid)
    else $error("conv4 middle byte not stored");

  property p_c1_hold;
    @(posedge pclk) disable iff (!presetn)
    !(wr_cyc && (idx == IDX_C1_LOW || idx == IDX_C1_MID ||
      idx == IDX_C1_TOP)) |-> ##2 $stable(conv1_step);
  endproperty
  a_c1_hold: assert property (p_c1_hold)
    else $error("conv1 step moved without a write");

  property p_c4_top;
    @(posedge pclk) disable iff (!presetn)
    conv4_step[17:16] == RST_TOP;
  endproperty
  a_c4_top: assert property (p_c4_top)
    else $error("conv4 top bits moved");

  property p_top_rsv;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && aligned && idx == IDX_C1_TOP) |=>
      pready && prdata[31:2] == 30'h00000000;
  endproperty
  a_top_rsv: assert property (p_top_rsv)
    else $error("reserved top bits not zero");

  property p_gate_r;
    @(posedge pclk) disable iff (!presetn)
    ##1 conv3_rd_en_right == $past(conv3_fill_right >= conv3_read_level_r);
  endproperty
  a_gate_r: assert property (p_gate_r)
    else $error("right read enable wrong");

  property p_lvl_keep;
    @(posedge pclk) disable iff (!presetn)
    !(wr_cyc && idx == IDX_C3_LVL) |=> $stable(conv3_read_level_r);
  endproperty
  a_lvl_keep: assert property (p_lvl_keep)
    else $error("read level moved without a write");
endmodule
`default_nettype wire

// ==== hw/rsc_pkg.sv ====
// Purpose: constants for the rate converter step configuration bank
// Assumes: registers are byte-wide, indices are 12 bits; byte address is index times four
// Notes:   reset values and field widths shared by all design files
`default_nettype none
package rsc_pkg;
  localparam int unsigned STEP_W     = 18;
  localparam int unsigned FRAC_W     = 16;
  localparam int unsigned LEVEL_W    = 4;
  localparam int unsigned NCONV      = 4;
  localparam int unsigned IDX_W      = 12;
  // register indices
  localparam logic [11:0] IDX_C1_LOW  = 12'h8F8;
  localparam logic [11:0] IDX_C1_MID  = 12'h8F9;
  localparam logic [11:0] IDX_C1_TOP  = 12'h8FA;
  localparam logic [11:0] IDX_TEST_A  = 12'h8FB;
  localparam logic [11:0] IDX_C2_LOW  = 12'h8FC;
  localparam logic [11:0] IDX_C2_MID  = 12'h8FD;
  localparam logic [11:0] IDX_C2_TOP  = 12'h8FE;
  localparam logic [11:0] IDX_TEST_B  = 12'h8FF;
  localparam logic [11:0] IDX_C3_LOW  = 12'h900;
  localparam logic [11:0] IDX_C3_MID  = 12'h901;
  localparam logic [11:0] IDX_C3_TOP  = 12'h902;
  localparam logic [11:0] IDX_C3_LVL  = 12'h903;
  localparam logic [11:0] IDX_C4_LOW  = 12'h904;
  localparam logic [11:0] IDX_C4_MID  = 12'h905;
  // reset values
  localparam logic [7:0] RST_C12_LOW = 8'h7C;
  localparam logic [7:0] RST_C12_MID = 8'h86;
  localparam logic [7:0] RST_C34_LOW = 8'hAA;
  localparam logic [7:0] RST_C34_MID = 8'h4F;
  localparam logic [1:0] RST_TOP     = 2'h1;
  localparam logic [3:0] RST_LEVEL   = 4'h8;
  localparam logic [7:0] RST_TEST    = 8'h04;
  localparam logic [17:0] STEP_UNITY = 18'h10000;
  typedef enum logic [1:0] {
    RSC_IDLE   = 2'b01,
    RSC_ACCESS = 2'b10
  } rsc_state_e;
endpackage
`default_nettype wire

// ==== hw/rsc_step_reg.sv ====
// Purpose: one converter's three step registers and assembled step
// Assumes: writes arrive as one-cycle strobes with byte data
// Notes:   upper bits above the two-bit field are not stored
`default_nettype none
module rsc_step_reg
  import rsc_pkg::*;
#(
  parameter logic [7:0] RST_LOW = 8'h00,
  parameter logic [7:0] RST_MID = 8'h00,
  parameter logic [1:0] RST_HI  = 2'h0,
  parameter bit         HAS_TOP = 1'b1
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              wr_low,
  input  wire logic              wr_mid,
  input  wire logic              wr_top,
  input  wire logic [7:0]        wdata,
  output logic      [STEP_W-1:0] step,
  output logic                   unity
);
  logic [7:0] low_r, low_nxt, mid_r, mid_nxt;
  logic [1:0] top_r, top_nxt;

  always_comb begin
    low_nxt = wr_low ? wdata : low_r;
    mid_nxt = wr_mid ? wdata : mid_r;
    top_nxt = (wr_top && HAS_TOP) ? wdata[1:0] : top_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_r <= RST_LOW;
      mid_r <= RST_MID;
      top_r <= RST_HI;
    end else begin
      low_r <= low_nxt;
      mid_r <= mid_nxt;
      top_r <= top_nxt;
    end
  end

  assign step  = {top_r, mid_r, low_r};
  assign unity = (step == STEP_UNITY);
endmodule
`default_nettype wire

// ==== hw/rsc_read_gate.sv ====
// Purpose: fifo read enable gate from a fill level and a threshold
// Assumes: fill level is a count of words already in the fifo
// Notes:   one instance per channel, sharing the threshold
`default_nettype none
module rsc_read_gate
  import rsc_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [LEVEL_W-1:0] fill,
  input  wire logic [LEVEL_W-1:0] level,
  output logic                    rd_en
);
  logic rd_en_r, rd_en_nxt;
  always_comb rd_en_nxt = (fill >= level);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rd_en_r <= 1'b0;
    else rd_en_r <= rd_en_nxt;
  end
  assign rd_en = rd_en_r;
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the converter step register bank
// Assumes: one-cycle apb answer; byte address is register index times four
// Notes:   table rows read resets first, then write and read back
`default_nettype none
module tb_top
  import rsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic        wr;
    logic [15:0] a;
    logic [7:0]  wd;
    logic [7:0]  ex;
  } rsc_row_s;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [3:0]  fill_l = 4'h0;
  logic [3:0]  fill_r = 4'h0;
  logic [17:0] s1, s2, s3, s4;
  logic        unity, en_l, en_r, er;
  logic [31:0] rd;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  rsc_row_s    rows [0:22] = '{
    '{0, 16'h23E0, 8'h00, 8'h7C}, '{0, 16'h23E4, 8'h00, 8'h86},
    '{0, 16'h23E8, 8'h00, 8'h01}, '{0, 16'h23EC, 8'h00, 8'h04},
    '{0, 16'h23F0, 8'h00, 8'h7C}, '{0, 16'h23F4, 8'h00, 8'h86},
    '{0, 16'h23F8, 8'h00, 8'h01}, '{0, 16'h23FC, 8'h00, 8'h04},
    '{0, 16'h2400, 8'h00, 8'hAA}, '{0, 16'h2404, 8'h00, 8'h4F},
    '{0, 16'h2408, 8'h00, 8'h01}, '{0, 16'h240C, 8'h00, 8'h08},
    '{0, 16'h2410, 8'h00, 8'hAA}, '{0, 16'h2414, 8'h00, 8'h4F},
    '{1, 16'h23E0, 8'hFF, 8'hFF}, '{1, 16'h23E8, 8'hFE, 8'h02},
    '{1, 16'h23EC, 8'h55, 8'h04}, '{1, 16'h2408, 8'hFF, 8'h03},
    '{1, 16'h240C, 8'hF5, 8'h05}, '{1, 16'h2410, 8'h12, 8'h12},
    '{1, 16'h2414, 8'h34, 8'h34}, '{1, 16'h23F4, 8'h00, 8'h00},
    '{1, 16'h23FC, 8'hAB, 8'h04}
  };

  rsc_config DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr),
    .conv3_fill_left(fill_l), .conv3_fill_right(fill_r),
    .conv1_step(s1), .conv2_step(s2), .conv3_step(s3), .conv4_step(s4),
    .conv1_unity(unity), .conv3_rd_en_left(en_l),
    .conv3_rd_en_right(en_r)
  );

  initial begin
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] got, ex);
    n_tests++;
    if (got !== ex) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // apb transfer; entered just after a rising edge, ends after one idle edge
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("c1 step", {14'h0, s1}, 32'h1867C);
    chk("c2 step", {14'h0, s2}, 32'h1867C);
    chk("c3 step", {14'h0, s3}, 32'h14FAA);
    chk("c4 step", {14'h0, s4}, 32'h14FAA);
    chk("unity", {31'h0, unity}, 32'h0);
    foreach (rows[i]) begin
      if (rows[i].wr) xfer(1'b1, rows[i].a, rows[i].wd);
      xfer(1'b0, rows[i].a, 8'h00);
      chk("reg", rd, {24'h0, rows[i].ex});
      chk("err", {31'h0, er}, 32'h0);
    end
    chk("c3 step", {14'h0, s3}, 32'h34FAA);
    chk("c4 step", {14'h0, s4}, 32'h13412);
    // unmapped and misaligned accesses refused
    xfer(1'b0, 16'h3000, 8'h00);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    xfer(1'b1, 16'h23E1, 8'h11);
    chk("misaligned err", {31'h0, er}, 32'h1);
    // unity step on converter 1
    xfer(1'b1, 16'h23E0, 8'h00);
    xfer(1'b1, 16'h23E4, 8'h00);
    xfer(1'b1, 16'h23E8, 8'h01);
    // step output lags the access edge by one more edge
    @(posedge pclk);
    chk("c1 unity step", {14'h0, s1}, 32'h10000);
    chk("unity", {31'h0, unity}, 32'h1);
    // level 5 shared by both channel gates
    fill_l <= 4'h5;
    fill_r <= 4'h4;
    repeat (3) @(posedge pclk);
    chk("rd en l", {31'h0, en_l}, 32'h1);
    chk("rd en r", {31'h0, en_r}, 32'h0);
    fill_r <= 4'h5;
    fill_l <= 4'h4;
    repeat (3) @(posedge pclk);
    chk("rd en l", {31'h0, en_l}, 32'h0);
    chk("rd en r", {31'h0, en_r}, 32'h1);
    fill_r <= 4'h6;
    fill_l <= 4'h6;
    repeat (3) @(posedge pclk);
    chk("rd en l eq", {31'h0, en_l}, 32'h1);
    chk("rd en r eq", {31'h0, en_r}, 32'h1);
    // second reset in mid-run restores defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("c1 rst", {14'h0, s1}, 32'h1867C);
    chk("c3 rst", {14'h0, s3}, 32'h14FAA);
    chk("en rst", {31'h0, en_r}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, 16'h240C, 8'h00);
    chk("level rst", rd, 32'h8);
    complete_run();
  end
endmodule
`default_nettype wire
